// File: hw/asr_status.sv
// second- and third-level audio event status with read-clear and mirror
`timescale 1ns/1ps
module asr_status (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire asr_pkg::asr_mem_req_t mem_i,
  output logic [31:0]              mem_rdata_o,
  output logic                     mem_rvalid_o,
  input  wire asr_pkg::asr_dma_t   dma_i,
  input  wire logic                codec_serial_irq_i,
  input  wire logic                codec_serial_irq_en_i,
  input  wire logic                codec_gpio_irq_i,
  input  wire logic                codec_gpio_irq_en_i,
  input  wire logic                fast_write_en_i,
  input  wire asr_pkg::asr_trap_t  trap_i,
  output logic                     top_status_o,
  output logic                     smi_req_o,
  output logic [15:0]              status_o
);

  localparam int NCH = asr_pkg::ASR_DMA_CH;

  logic [NCH-1:0]  page_end_r;
  logic [NCH-1:0]  dma_set;
  logic [15:0]     sl_q;
  logic [15:0]     sl_view;
  logic [31:0]     trap_r;
  logic            rd_rc;
  logic            rd_mir;
  logic            rd_trap;
  logic            codec_set;
  logic            fast_wr;
  logic            fast_even;
  logic            fast_odd;
  logic            trap_event;
  logic            plain_wr;
  logic [3:0]      flag_set;
  logic [3:0]      flag_q;
  logic            any_flag;

  // address decode of the memory window
  function automatic logic hit(input asr_pkg::asr_mem_req_t m, input logic [7:0] ofs);
    hit = m.rd & (m.addr == ofs);
  endfunction : hit

  always_comb begin
    rd_rc   = hit(mem_i, asr_pkg::ASR_OFS_STAT_RC);
    rd_mir  = hit(mem_i, asr_pkg::ASR_OFS_STAT_MIR);
    rd_trap = hit(mem_i, asr_pkg::ASR_OFS_TRAP);
  end

  // page end edge detect per channel
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_end_r <= '0;
    end else begin
      page_end_r <= dma_i.page_end;
    end
  end

  // only the rising edge counts so a standing flag does not re-arm
  always_comb begin
    dma_set = dma_i.enable & dma_i.page_end & ~page_end_r;
  end

  always_comb begin
    codec_set = (codec_serial_irq_i & codec_serial_irq_en_i) |
                (codec_gpio_irq_i & codec_gpio_irq_en_i);
  end

  // trapped access classification
  always_comb begin
    fast_wr    = trap_i.valid & trap_i.write & trap_i.fast & fast_write_en_i;
    fast_even  = fast_wr & ~trap_i.address_bit_zero;
    fast_odd   = fast_wr & trap_i.address_bit_zero;
    plain_wr   = trap_i.valid & trap_i.write & ~fast_wr;
    trap_event = trap_i.valid & ~fast_even;
  end

  // third-level flag sets: [3]=fast synth, [2]=dma, [1]=midi, [0]=synth
  always_comb begin
    flag_set = 4'h0;
    if (trap_event) begin
      if (fast_odd) begin
        flag_set[3] = 1'b1;
      end else begin
        case (trap_i.kind)
          asr_pkg::ASR_TRAP_DMA:   flag_set[2] = 1'b1;
          asr_pkg::ASR_TRAP_MIDI:  flag_set[1] = 1'b1;
          asr_pkg::ASR_TRAP_SYNTH: begin
            if (fast_write_en_i) begin
              flag_set[3] = 1'b1;
            end else begin
              flag_set[0] = 1'b1;
            end
          end
          default:                 flag_set = 4'h0;
        endcase
      end
    end
  end

  // trap flags, cleared by reading the trap register
  genvar gf;
  generate
    for (gf = 0; gf < 4; gf++) begin : g_flag
      asr_sticky u_flag (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .set_i  (flag_set[gf]),
        .clr_i  (rd_trap),
        .hold_i (1'b0),
        .q_o    (flag_q[gf])
      );
    end
  endgenerate

  always_comb begin
    any_flag = |flag_q;
  end

  // capture fields; they survive the trap read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trap_r <= asr_pkg::ASR_TR_RESET;
    end else if (trap_i.valid) begin
      if (fast_even) begin
        trap_r[asr_pkg::ASR_TR_EVEN_MSB:asr_pkg::ASR_TR_EVEN_LSB] <= trap_i.data;
      end
      if (fast_odd | plain_wr) begin
        trap_r[asr_pkg::ASR_TR_ODD_MSB:asr_pkg::ASR_TR_ODD_LSB] <= trap_i.data;
      end
      if (fast_wr) begin
        trap_r[asr_pkg::ASR_TR_A1] <= trap_i.address_bit_one;
      end
      trap_r[asr_pkg::ASR_TR_DIR] <= trap_i.write;
      trap_r[asr_pkg::ASR_TR_XADDR_MSB:0] <= trap_i.xbus_addr;
    end
  end

  // second-level flags
  asr_sticky u_sl_trap (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .set_i  (trap_event),
    .clr_i  (rd_rc),
    .hold_i (any_flag),
    .q_o    (sl_q[asr_pkg::ASR_SL_TRAP])
  );

  asr_sticky u_sl_codec (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .set_i  (codec_set),
    .clr_i  (rd_rc),
    .hold_i (1'b0),
    .q_o    (sl_q[asr_pkg::ASR_SL_CODEC])
  );

  genvar gc;
  generate
    for (gc = 0; gc < NCH; gc++) begin : g_dma
      asr_sticky u_sl_dma (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .set_i  (dma_set[gc]),
        .clr_i  (rd_rc),
        .hold_i (dma_i.page_end[gc]),
        .q_o    (sl_q[asr_pkg::ASR_SL_DMA_LSB + gc])
      );
    end
  endgenerate

  // reserved upper byte is never stored
  assign sl_q[asr_pkg::ASR_SL_W-1:asr_pkg::ASR_SL_DMA_LSB+NCH] = '0;

  // trap bit also shows any standing third-level flag
  always_comb begin
    sl_view = sl_q;
    sl_view[asr_pkg::ASR_SL_TRAP] = sl_q[asr_pkg::ASR_SL_TRAP] | any_flag;
  end

  // read data; the 10h read clears second-level flags and the 14h read clears trap flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_rdata_o  <= asr_pkg::ASR_WORD_ZERO;
      mem_rvalid_o <= 1'b0;
    end else begin
      mem_rvalid_o <= mem_i.rd;
      if (rd_rc | rd_mir) begin
        mem_rdata_o <= {16'h0000, sl_view};
      end else if (rd_trap) begin
        mem_rdata_o <= {trap_r[asr_pkg::ASR_TR_EVEN_MSB:asr_pkg::ASR_TR_DIR], flag_q,
                        trap_r[asr_pkg::ASR_TR_XADDR_MSB:0]};
      end else if (mem_i.rd) begin
        mem_rdata_o <= asr_pkg::ASR_WORD_ZERO;
      end
    end
  end

  // summary outputs lag the status by one cycle to stay registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      top_status_o <= 1'b0;
      smi_req_o    <= 1'b0;
      status_o     <= asr_pkg::ASR_SL_RESET;
    end else begin
      top_status_o <= |sl_view;
      smi_req_o    <= |sl_view;
      status_o     <= sl_view;
    end
  end

endmodule : asr_status

// File: hw/asr_sticky.sv
// one sticky status flag: set wins over clear, clear held off by a source level
`timescale 1ns/1ps
module asr_sticky (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  input  wire logic hold_i,
  output logic      q_o
);

  logic q_nxt;

  // a source level still present blocks the clear
  always_comb begin
    q_nxt = set_i | (q_o & ~(clr_i & ~hold_i));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= 1'b0;
    end else begin
      q_o <= q_nxt;
    end
  end

endmodule : asr_sticky

// File: pkg/asr_pkg.sv
// constants and carrier types for the audio event status logic
package asr_pkg;

  localparam int          ASR_DMA_CH        = 6;
  localparam int          ASR_ADDR_W        = 8;

  // memory window offsets
  localparam logic [7:0]  ASR_OFS_STAT_RC   = 8'h10;
  localparam logic [7:0]  ASR_OFS_STAT_MIR  = 8'h12;
  localparam logic [7:0]  ASR_OFS_TRAP      = 8'h14;

  // second-level status layout
  localparam int          ASR_SL_TRAP       = 0;
  localparam int          ASR_SL_CODEC      = 1;
  localparam int          ASR_SL_DMA_LSB    = 2;
  localparam int          ASR_SL_W          = 16;
  localparam logic [15:0] ASR_SL_RESET      = 16'h0000;

  // trap status layout
  localparam int          ASR_TR_EVEN_MSB   = 31;
  localparam int          ASR_TR_EVEN_LSB   = 24;
  localparam int          ASR_TR_ODD_MSB    = 23;
  localparam int          ASR_TR_ODD_LSB    = 16;
  localparam int          ASR_TR_A1         = 15;
  localparam int          ASR_TR_DIR        = 14;
  localparam int          ASR_TR_FAST_SND   = 13;
  localparam int          ASR_TR_DMA        = 12;
  localparam int          ASR_TR_MIDI       = 11;
  localparam int          ASR_TR_SND        = 10;
  localparam int          ASR_TR_XADDR_MSB  = 9;
  localparam logic [31:0] ASR_TR_RESET      = 32'h0000_0000;
  localparam logic [7:0]  ASR_BYTE_ZERO     = 8'h00;
  localparam logic [31:0] ASR_WORD_ZERO     = 32'h0000_0000;

  // which trap a trapped access hit
  typedef enum logic [1:0] {
    ASR_TRAP_DMA   = 2'b00,
    ASR_TRAP_MIDI  = 2'b01,
    ASR_TRAP_SYNTH = 2'b11
  } asr_trap_kind_t;

  typedef struct packed {
    logic [ASR_DMA_CH-1:0] enable;
    logic [ASR_DMA_CH-1:0] page_end;
  } asr_dma_t;

  typedef struct packed {
    logic                  valid;
    asr_trap_kind_t        kind;
    logic                  write;
    logic                  fast;
    logic                  address_bit_zero;
    logic                  address_bit_one;
    logic [9:0]            xbus_addr;
    logic [7:0]            data;
  } asr_trap_t;

  typedef struct packed {
    logic                  rd;
    logic [ASR_ADDR_W-1:0] addr;
  } asr_mem_req_t;

endpackage : asr_pkg

// File: tb/asr_status_checker.sv
// assertion checker for the audio event status block
`timescale 1ns/1ps
module asr_status_checker (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire asr_pkg::asr_dma_t   dma_i,
  input wire logic                codec_serial_irq_i,
  input wire logic                codec_serial_irq_en_i,
  input wire logic                codec_gpio_irq_i,
  input wire logic                codec_gpio_irq_en_i,
  input wire asr_pkg::asr_trap_t  trap_i,
  input wire logic                top_status_o,
  input wire logic                smi_req_o,
  input wire logic [15:0]         status_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_TOP_ANY: assert property (top_status_o == (|status_o))
    else $error("top status does not follow status");
  AST_REQ_ANY: assert property (smi_req_o == (|status_o))
    else $error("request does not follow status");
  AST_RSV_ZERO: assert property (status_o[15:8] == 8'h00)
    else $error("reserved status bits set");
  AST_DMA0_SET: assert property ($rose(dma_i.page_end[0]) && dma_i.enable[0]
    |-> ##2 status_o[2])
    else $error("channel 0 event missing");
  AST_DMA3_SET: assert property ($rose(dma_i.page_end[3]) && dma_i.enable[3]
    |-> ##2 status_o[5])
    else $error("channel 3 event missing");
  AST_DMA_HOLD: assert property (status_o[2] && $past(dma_i.page_end[0])
    && dma_i.page_end[0] |=> status_o[2])
    else $error("channel 0 bit cleared under page end");
  AST_CODEC_SET: assert property ((codec_serial_irq_i && codec_serial_irq_en_i) ||
    (codec_gpio_irq_i && codec_gpio_irq_en_i) |-> ##2 status_o[1])
    else $error("codec event missing");
  AST_TRAP_ODD: assert property (trap_i.valid && trap_i.write && trap_i.fast
    && trap_i.address_bit_zero |-> ##2 status_o[0])
    else $error("odd trap event missing");
endmodule : asr_status_checker

bind asr_status asr_status_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .dma_i(dma_i),
  .codec_serial_irq_i(codec_serial_irq_i), .codec_serial_irq_en_i(codec_serial_irq_en_i),
  .codec_gpio_irq_i(codec_gpio_irq_i), .codec_gpio_irq_en_i(codec_gpio_irq_en_i),
  .trap_i(trap_i), .top_status_o(top_status_o), .smi_req_o(smi_req_o), .status_o(status_o));

// File: tb/test_asr_status.sv
// self-checking bench for the audio event status block
`timescale 1ns/1ps
module test_asr_status;
  logic                  clk_i = 1'b0;
  logic                  rst_i = 1'b1;
  asr_pkg::asr_mem_req_t mem_i = '0;
  asr_pkg::asr_dma_t     dma_i = '0;
  asr_pkg::asr_trap_t    trap_i = '0;
  logic [3:0]            cod = 4'h0;
  logic                  few = 1'b0;
  logic [31:0]           mem_rdata_o;
  logic                  mem_rvalid_o;
  logic                  top_status_o;
  logic                  smi_req_o;
  logic [15:0]           status_o;
  logic [31:0]           v;
  int                    mismatches = 0;
  int                    cmp_count = 0;
  always #2.5 clk_i = ~clk_i;
  asr_status dut_u (.clk_i(clk_i), .rst_i(rst_i), .mem_i(mem_i), .mem_rdata_o(mem_rdata_o),
    .mem_rvalid_o(mem_rvalid_o), .dma_i(dma_i), .codec_serial_irq_i(cod[3]),
    .codec_serial_irq_en_i(cod[2]), .codec_gpio_irq_i(cod[1]), .codec_gpio_irq_en_i(cod[0]),
    .fast_write_en_i(few), .trap_i(trap_i), .top_status_o(top_status_o),
    .smi_req_o(smi_req_o), .status_o(status_o));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // one-cycle strobe, data taken with the valid pulse
  task automatic rd(input logic [7:0] a);
    @(negedge clk_i);
    mem_i = {1'b1, a};
    @(negedge clk_i);
    mem_i.rd = 1'b0;
    chk({31'h0, mem_rvalid_o}, 32'h1);
    v = mem_rdata_o;
  endtask : rd
  // f is write, fast, odd, address bit one
  task automatic trap(input logic [1:0] k, input logic [3:0] f, input logic [9:0] x,
                      input logic [7:0] d);
    @(negedge clk_i);
    trap_i = {1'b1, k, f, x, d};
    @(negedge clk_i);
    trap_i.valid = 1'b0;
  endtask : trap
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    #20000;
    mismatches++;
    complete_run();
  end
  initial begin
    repeat (4) @(negedge clk_i);
    rst_i = 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(8'h10 + 8'(2 * i));
      chk(v, 32'h0);
    end
    for (int i = 0; i < 6; i++) begin
      dma_i.page_end[i] = 1'b1;
      repeat (2) @(negedge clk_i);
      chk({16'h0, status_o}, 32'h0);
      dma_i.page_end[i] = 1'b0;
      dma_i.enable[i] = 1'b1;
      @(negedge clk_i);
      dma_i.page_end[i] = 1'b1;
      repeat (2) @(negedge clk_i);
      chk({31'h0, smi_req_o}, 32'h1);
      rd(8'h10);
      rd(8'h12);
      chk(v, 32'h4 << i);
      dma_i.page_end[i] = 1'b0;
      rd(8'h10);
      rd(8'h12);
      chk(v, 32'h0);
      chk({31'h0, top_status_o}, 32'h0);
      dma_i.enable[i] = 1'b0;
    end
    cod = 4'b1000;
    repeat (2) @(negedge clk_i);
    chk({16'h0, status_o}, 32'h0);
    cod = 4'b0011;
    @(negedge clk_i);
    cod = 4'b0000;
    rd(8'h12);
    rd(8'h12);
    chk(v, 32'h2);
    rd(8'h10);
    cod = 4'b1100;
    @(negedge clk_i);
    cod = 4'b0000;
    rd(8'h12);
    chk(v, 32'h2);
    rd(8'h10);
    few = 1'b1;
    trap(2'b11, 4'b1101, 10'h38a, 8'ha5);
    rd(8'h14);
    chk(v, {8'ha5, 8'h00, 2'b11, 4'h0, 10'h38a});
    chk({16'h0, status_o}, 32'h0);
    trap(2'b11, 4'b1110, 10'h389, 8'h3c);
    rd(8'h12);
    chk(v, 32'h1);
    rd(8'h14);
    chk(v, {8'ha5, 8'h3c, 2'b01, 4'b1000, 10'h389});
    rd(8'h14);
    chk(v, {8'ha5, 8'h3c, 2'b01, 4'h0, 10'h389});
    few = 1'b0;
    trap(2'b11, 4'b0000, 10'h220, 8'h77);
    rd(8'h14);
    chk(v, {8'ha5, 8'h3c, 2'b00, 4'b0001, 10'h220});
    trap(2'b01, 4'b1000, 10'h330, 8'h5a);
    rd(8'h14);
    chk(v, {8'ha5, 8'h5a, 2'b01, 4'b0010, 10'h330});
    trap(2'b00, 4'b0000, 10'h0c0, 8'h11);
    rd(8'h14);
    chk(v, {8'ha5, 8'h5a, 2'b00, 4'b0100, 10'h0c0});
    rd(8'h10);
    rd(8'h12);
    chk(v, 32'h0);
    complete_run();
  end
endmodule : test_asr_status
